// *** hdl/cmpd_pkg.sv ***
// Constants, register map and state types for the current monitor peak detector
package cmpd_pkg;

  localparam logic [7:0] CMPD_CUR_HIGH_OFF [2]  = '{8'h00, 8'h04};
  localparam logic [7:0] CMPD_CUR_LOW_OFF  [2]  = '{8'h01, 8'h05};
  localparam logic [7:0] CMPD_MIN_HIGH_OFF [2]  = '{8'h08, 8'h10};
  localparam logic [7:0] CMPD_MIN_LOW_OFF  [2]  = '{8'h09, 8'h11};
  localparam logic [7:0] CMPD_MAX_HIGH_OFF [2]  = '{8'h0A, 8'h12};
  localparam logic [7:0] CMPD_MAX_LOW_OFF  [2]  = '{8'h0B, 8'h13};
  localparam logic [7:0] CMPD_WARN_HIGH_OFF [2] = '{8'h22, 8'h2C};
  localparam logic [7:0] CMPD_WARN_LOW_OFF  [2] = '{8'h23, 8'h2D};
  localparam logic [7:0] CMPD_FAST_TRIP_OFF [2] = '{8'h2E, 8'h2F};
  localparam logic [7:0] CMPD_RANGE_STATUS_OFF  = 8'h33;
  localparam logic [7:0] CMPD_PEAK_CLEAR_OFF    = 8'h41;

  localparam logic [7:0] CMPD_FAST_TRIP_RESET   = 8'hBF;
  localparam logic [9:0] CMPD_MIN_RESET         = 10'h3FF;
  localparam logic [9:0] CMPD_MAX_RESET         = 10'h000;
  localparam logic [9:0] CMPD_WARN_RESET        = 10'h3FF;
  localparam logic [9:0] CMPD_RESULT_RESET      = 10'h000;

  localparam logic [1:0] CMPD_RANGE_25MV        = 2'h2;
  localparam logic [1:0] CMPD_RANGE_50MV        = 2'h1;
  localparam logic [1:0] CMPD_RANGE_100MV       = 2'h0;
  localparam int         CMPD_FS_25MV_UV        = 25000;
  localparam int         CMPD_FS_50MV_UV        = 50000;
  localparam int         CMPD_FS_100MV_UV       = 100000;
  localparam int         CMPD_FT_MIN_PCT        = 40;
  localparam int         CMPD_FT_MAX_PCT        = 100;
  localparam int         CMPD_FT_CODE_SPAN      = 255;

  typedef enum logic [2:0] {
    CMPD_IDLE     = 3'b000,
    CMPD_ADDR     = 3'b001,
    CMPD_ACK_ADDR = 3'b010,
    CMPD_WRITE    = 3'b011,
    CMPD_ACK_WR   = 3'b100,
    CMPD_READ     = 3'b101,
    CMPD_ACK_RD   = 3'b110
  } cmpd_link_state_t;

  typedef struct packed {
    logic [9:0] resultReg;
    logic [9:0] minReg;
    logic [9:0] maxReg;
    logic [9:0] warnLevelReg;
    logic       warnReg;
  } cmpd_chan_t;

  typedef struct packed {
    cmpd_link_state_t linkState;
    logic [3:0]       bitCnt;
    logic [7:0]       shift;
    logic [7:0]       pointer;
    logic             firstByte;
    logic             readDir;
    logic             masterNack;
    logic             sclPrev;
    logic             sdaPrev;
    logic             sdaOe;
    logic             wrStrobe;
    logic [7:0]       wrAddr;
    logic [7:0]       wrData;
    logic [3:0]       rangeCode;
    logic             rangeLoaded;
    logic [7:0]       fastTrip0;
    logic [7:0]       fastTrip1;
    logic [1:0]       peakClear;
    logic             alert;
    logic [16:0]      fastTripUv0;
    logic [16:0]      fastTripUv1;
  } cmpd_top_t;

endpackage

// *** hdl/cmpd_channel.sv ***
// One channel: latest current result, min/max peaks and warning comparator
`timescale 1ns/1ps
`default_nettype none
module cmpd_channel (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       sampleValid,
  input  wire logic [9:0] sampleData,
  input  wire logic       powerGood,
  input  wire logic       peakReload,
  input  wire logic       warnWrHigh,
  input  wire logic       warnWrLow,
  input  wire logic [7:0] wrData,
  output logic      [9:0] result,
  output logic      [9:0] minPeak,
  output logic      [9:0] maxPeak,
  output logic      [9:0] warnLevel,
  output logic            warnActive
);

  cmpd_pkg::cmpd_chan_t chan_reg;
  cmpd_pkg::cmpd_chan_t chan_next;

  always_comb begin
    chan_next = chan_reg;
    if (sampleValid) begin
      chan_next.resultReg = sampleData;
      if (sampleData > chan_reg.maxReg) begin
        chan_next.maxReg = sampleData;
      end
      if (sampleData < chan_reg.minReg) begin
        chan_next.minReg = sampleData;
      end
      // Protection mode is deliberately not an input here
      if (powerGood) begin
        chan_next.warnReg = (sampleData > chan_reg.warnLevelReg);
      end
    end
    if (!powerGood) begin
      chan_next.warnReg = 1'b0;
    end
    // Reload beats a coincident sample so a fresh log starts clean
    if (peakReload) begin
      chan_next.minReg = cmpd_pkg::CMPD_MIN_RESET;
      chan_next.maxReg = cmpd_pkg::CMPD_MAX_RESET;
    end
    if (warnWrHigh) begin
      chan_next.warnLevelReg[9:2] = wrData;
    end
    if (warnWrLow) begin
      chan_next.warnLevelReg[1:0] = wrData[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chan_reg.resultReg    <= cmpd_pkg::CMPD_RESULT_RESET;
      chan_reg.minReg       <= cmpd_pkg::CMPD_MIN_RESET;
      chan_reg.maxReg       <= cmpd_pkg::CMPD_MAX_RESET;
      chan_reg.warnLevelReg <= cmpd_pkg::CMPD_WARN_RESET;
      chan_reg.warnReg      <= 1'b0;
    end else begin
      chan_reg <= chan_next;
    end
  end

  assign result     = chan_reg.resultReg;
  assign minPeak    = chan_reg.minReg;
  assign maxPeak    = chan_reg.maxReg;
  assign warnLevel  = chan_reg.warnLevelReg;
  assign warnActive = chan_reg.warnReg;

endmodule
`default_nettype wire

// *** hdl/cmpd_monitor.sv ***
// Current monitor top: two-wire register slave, range code, fast-trip setting
`timescale 1ns/1ps
`default_nettype none
module cmpd_monitor #(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       sampleValid,
  input  wire logic       sampleChannel,
  input  wire logic [9:0] sampleData,
  input  wire logic [1:0] powerGoodOut,
  input  wire logic [1:0] protectionModePin,
  input  wire logic [1:0] channelStart,
  input  wire logic [1:0] rangeSelectPinDriven,
  input  wire logic [1:0] rangeSelectPinLevel,
  output logic            alertOut,
  output logic      [3:0] rangeCode,
  output logic      [7:0] fastTripSetting0,
  output logic      [7:0] fastTripSetting1,
  output logic     [16:0] fastTripUv0,
  output logic     [16:0] fastTripUv1
);

  cmpd_pkg::cmpd_top_t top_reg;
  cmpd_pkg::cmpd_top_t top_next;

  logic [1:0][9:0] chResult;
  logic [1:0][9:0] chMin;
  logic [1:0][9:0] chMax;
  logic [1:0][9:0] chWarnLevel;
  logic      [1:0] chWarn;
  logic      [1:0] chSample;
  logic      [1:0] chReload;
  logic      [1:0] warnWrHigh;
  logic      [1:0] warnWrLow;
  logic      [7:0] rdByte;
  logic            sclRise;
  logic            sclFall;
  logic            startCond;
  logic            stopCond;

  // Protection mode only affects the analog fault path, not this block
  logic [1:0] protModeUnused;
  assign protModeUnused = protectionModePin;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      // One converter is shared; the channel tag steers each sample
      assign chSample[gi]   = sampleValid && (sampleChannel == 1'(gi));
      assign chReload[gi]   = channelStart[gi] | top_reg.peakClear[gi];
      assign warnWrHigh[gi] = top_reg.wrStrobe
                              && (top_reg.wrAddr == cmpd_pkg::CMPD_WARN_HIGH_OFF[gi]);
      assign warnWrLow[gi]  = top_reg.wrStrobe
                              && (top_reg.wrAddr == cmpd_pkg::CMPD_WARN_LOW_OFF[gi]);
      cmpd_channel u_chan (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .sampleValid(chSample[gi]),
        .sampleData (sampleData),
        .powerGood  (powerGoodOut[gi]),
        .peakReload (chReload[gi]),
        .warnWrHigh (warnWrHigh[gi]),
        .warnWrLow  (warnWrLow[gi]),
        .wrData     (top_reg.wrData),
        .result     (chResult[gi]),
        .minPeak    (chMin[gi]),
        .maxPeak    (chMax[gi]),
        .warnLevel  (chWarnLevel[gi]),
        .warnActive (chWarn[gi])
      );
    end
  endgenerate

  function automatic logic [1:0] pinToRange(input logic driven, input logic level);
    logic [1:0] code;
    code = cmpd_pkg::CMPD_RANGE_100MV;
    if (driven) begin
      code = level ? cmpd_pkg::CMPD_RANGE_50MV : cmpd_pkg::CMPD_RANGE_25MV;
    end
    return code;
  endfunction

  // 40 % at code 0 rising linearly to 100 % at code 255
  function automatic logic [16:0] fastTripUv(input logic [1:0] rng, input logic [7:0] code);
    // 64-bit: full scale times code span overflows 32 bits on the 100 mV range
    longint fullScale;
    longint numer;
    longint denom;
    fullScale = cmpd_pkg::CMPD_FS_100MV_UV;
    if (rng == cmpd_pkg::CMPD_RANGE_25MV) begin
      fullScale = cmpd_pkg::CMPD_FS_25MV_UV;
    end else if (rng == cmpd_pkg::CMPD_RANGE_50MV) begin
      fullScale = cmpd_pkg::CMPD_FS_50MV_UV;
    end
    numer = cmpd_pkg::CMPD_FT_MIN_PCT * cmpd_pkg::CMPD_FT_CODE_SPAN
            + (cmpd_pkg::CMPD_FT_MAX_PCT - cmpd_pkg::CMPD_FT_MIN_PCT) * int'(code);
    denom = cmpd_pkg::CMPD_FT_MAX_PCT * cmpd_pkg::CMPD_FT_CODE_SPAN;
    return 17'((fullScale * numer) / denom);
  endfunction

  always_comb begin
    rdByte = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (top_reg.pointer == cmpd_pkg::CMPD_CUR_HIGH_OFF[i]) begin
        rdByte = chResult[i][9:2];
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_CUR_LOW_OFF[i]) begin
        rdByte = {6'h00, chResult[i][1:0]};
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_MIN_HIGH_OFF[i]) begin
        rdByte = chMin[i][9:2];
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_MIN_LOW_OFF[i]) begin
        rdByte = {6'h00, chMin[i][1:0]};
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_MAX_HIGH_OFF[i]) begin
        rdByte = chMax[i][9:2];
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_MAX_LOW_OFF[i]) begin
        rdByte = {6'h00, chMax[i][1:0]};
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_WARN_HIGH_OFF[i]) begin
        rdByte = chWarnLevel[i][9:2];
      end
      if (top_reg.pointer == cmpd_pkg::CMPD_WARN_LOW_OFF[i]) begin
        rdByte = {6'h00, chWarnLevel[i][1:0]};
      end
    end
    if (top_reg.pointer == cmpd_pkg::CMPD_FAST_TRIP_OFF[0]) begin
      rdByte = top_reg.fastTrip0;
    end
    if (top_reg.pointer == cmpd_pkg::CMPD_FAST_TRIP_OFF[1]) begin
      rdByte = top_reg.fastTrip1;
    end
    if (top_reg.pointer == cmpd_pkg::CMPD_RANGE_STATUS_OFF) begin
      rdByte = {4'h0, top_reg.rangeCode};
    end
  end

  assign sclRise   = scl && !top_reg.sclPrev;
  assign sclFall   = !scl && top_reg.sclPrev;
  assign startCond = scl && top_reg.sclPrev && top_reg.sdaPrev && !sdaIn;
  assign stopCond  = scl && top_reg.sclPrev && !top_reg.sdaPrev && sdaIn;

  always_comb begin
    top_next           = top_reg;
    top_next.sclPrev   = scl;
    top_next.sdaPrev   = sdaIn;
    top_next.wrStrobe  = 1'b0;
    top_next.peakClear = 2'h0;
    if (startCond) begin
      top_next.linkState = cmpd_pkg::CMPD_ADDR;
      top_next.bitCnt    = 4'h0;
      top_next.sdaOe     = 1'b0;
    end else if (stopCond) begin
      top_next.linkState = cmpd_pkg::CMPD_IDLE;
      top_next.sdaOe     = 1'b0;
    end else begin
      unique case (top_reg.linkState)
        cmpd_pkg::CMPD_IDLE: begin
        end
        cmpd_pkg::CMPD_ADDR: begin
          if (sclRise) begin
            top_next.shift  = {top_reg.shift[6:0], sdaIn};
            top_next.bitCnt = top_reg.bitCnt + 4'h1;
          end else if (sclFall && top_reg.bitCnt == 4'h8) begin
            if (top_reg.shift[7:1] == DEV_ADDR) begin
              top_next.linkState = cmpd_pkg::CMPD_ACK_ADDR;
              top_next.sdaOe     = 1'b1;
              top_next.readDir   = top_reg.shift[0];
            end else begin
              top_next.linkState = cmpd_pkg::CMPD_IDLE;
            end
          end
        end
        cmpd_pkg::CMPD_ACK_ADDR: begin
          if (sclFall) begin
            top_next.bitCnt = 4'h0;
            if (top_reg.readDir) begin
              top_next.linkState = cmpd_pkg::CMPD_READ;
              top_next.shift     = rdByte;
              top_next.sdaOe     = !rdByte[7];
            end else begin
              top_next.linkState = cmpd_pkg::CMPD_WRITE;
              top_next.firstByte = 1'b1;
              top_next.sdaOe     = 1'b0;
            end
          end
        end
        cmpd_pkg::CMPD_WRITE: begin
          if (sclRise) begin
            top_next.shift  = {top_reg.shift[6:0], sdaIn};
            top_next.bitCnt = top_reg.bitCnt + 4'h1;
          end else if (sclFall && top_reg.bitCnt == 4'h8) begin
            top_next.linkState = cmpd_pkg::CMPD_ACK_WR;
            top_next.sdaOe     = 1'b1;
            if (top_reg.firstByte) begin
              top_next.pointer   = top_reg.shift;
              top_next.firstByte = 1'b0;
            end else begin
              top_next.wrStrobe = 1'b1;
              top_next.wrAddr   = top_reg.pointer;
              top_next.wrData   = top_reg.shift;
              top_next.pointer  = top_reg.pointer + 8'h01;
            end
          end
        end
        cmpd_pkg::CMPD_ACK_WR: begin
          if (sclFall) begin
            top_next.linkState = cmpd_pkg::CMPD_WRITE;
            top_next.sdaOe     = 1'b0;
            top_next.bitCnt    = 4'h0;
          end
        end
        cmpd_pkg::CMPD_READ: begin
          if (sclRise) begin
            top_next.bitCnt = top_reg.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (top_reg.bitCnt == 4'h8) begin
              top_next.linkState = cmpd_pkg::CMPD_ACK_RD;
              top_next.sdaOe     = 1'b0;
              top_next.pointer   = top_reg.pointer + 8'h01;
            end else begin
              top_next.shift = {top_reg.shift[6:0], 1'b0};
              top_next.sdaOe = !top_reg.shift[6];
            end
          end
        end
        cmpd_pkg::CMPD_ACK_RD: begin
          if (sclRise) begin
            top_next.masterNack = sdaIn;
          end else if (sclFall) begin
            top_next.bitCnt = 4'h0;
            if (top_reg.masterNack) begin
              top_next.linkState = cmpd_pkg::CMPD_IDLE;
            end else begin
              top_next.linkState = cmpd_pkg::CMPD_READ;
              top_next.shift     = rdByte;
              top_next.sdaOe     = !rdByte[7];
            end
          end
        end
        default: begin
          top_next.linkState = cmpd_pkg::CMPD_IDLE;
          top_next.sdaOe     = 1'b0;
        end
      endcase
    end
    // Strap caught once, on the first edge after reset release
    if (!top_reg.rangeLoaded) begin
      top_next.rangeLoaded = 1'b1;
      top_next.rangeCode   = {pinToRange(rangeSelectPinDriven[1], rangeSelectPinLevel[1]),
                              pinToRange(rangeSelectPinDriven[0], rangeSelectPinLevel[0])};
    end
    // Peak and result offsets have no write path at all
    if (top_reg.wrStrobe) begin
      if (top_reg.wrAddr == cmpd_pkg::CMPD_FAST_TRIP_OFF[0]) begin
        top_next.fastTrip0 = top_reg.wrData;
      end
      if (top_reg.wrAddr == cmpd_pkg::CMPD_FAST_TRIP_OFF[1]) begin
        top_next.fastTrip1 = top_reg.wrData;
      end
      if (top_reg.wrAddr == cmpd_pkg::CMPD_RANGE_STATUS_OFF) begin
        top_next.rangeCode = top_reg.wrData[3:0];
      end
      if (top_reg.wrAddr == cmpd_pkg::CMPD_PEAK_CLEAR_OFF) begin
        top_next.peakClear = top_reg.wrData[1:0];
      end
    end
    top_next.alert       = |chWarn;
    top_next.fastTripUv0 = fastTripUv(top_reg.rangeCode[1:0], top_reg.fastTrip0);
    top_next.fastTripUv1 = fastTripUv(top_reg.rangeCode[3:2], top_reg.fastTrip1);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      top_reg             <= '0;
      top_reg.linkState   <= cmpd_pkg::CMPD_IDLE;
      top_reg.sclPrev     <= 1'b1;
      top_reg.sdaPrev     <= 1'b1;
      top_reg.fastTrip0   <= cmpd_pkg::CMPD_FAST_TRIP_RESET;
      top_reg.fastTrip1   <= cmpd_pkg::CMPD_FAST_TRIP_RESET;
    end else begin
      top_reg <= top_next;
    end
  end

  // Open-drain: only ever pulls low
  assign sdaOut           = 1'b0;
  assign sdaOe            = top_reg.sdaOe;
  assign alertOut         = top_reg.alert;
  assign rangeCode        = top_reg.rangeCode;
  assign fastTripSetting0 = top_reg.fastTrip0;
  assign fastTripSetting1 = top_reg.fastTrip1;
  assign fastTripUv0      = top_reg.fastTripUv0;
  assign fastTripUv1      = top_reg.fastTripUv1;

endmodule
`default_nettype wire

// *** testbench/cmpd_chk_monitor.sv ***
// Port-level assertions for the current monitor top
`timescale 1ns/1ps
`default_nettype none
module cmpd_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        sdaOe,
  input wire logic        sampleValid,
  input wire logic        sampleChannel,
  input wire logic [1:0]  powerGoodOut,
  input wire logic [1:0]  protectionModePin,
  input wire logic [1:0]  rangeSelectPinDriven,
  input wire logic [1:0]  rangeSelectPinLevel,
  input wire logic        alertOut,
  input wire logic [3:0]  rangeCode,
  input wire logic [7:0]  fastTripSetting0,
  input wire logic [7:0]  fastTripSetting1,
  input wire logic [16:0] fastTripUv0,
  input wire logic [16:0] fastTripUv1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  function automatic logic [1:0] pinCode(input logic drv, input logic lvl);
    return drv ? (lvl ? 2'h1 : 2'h2) : 2'h0;
  endfunction

  // Wide arithmetic: full scale times code span overflows 32 bits
  function automatic logic [16:0] ftUv(input logic [7:0] c, input logic [1:0] r);
    longint fs;
    fs = (r == 2'h2) ? 25000 : (r == 2'h1) ? 50000 : 100000;
    return 17'(fs * (10200 + 60 * longint'(c)) / 25500);
  endfunction

  AST_RANGE_PIN:
    assert property ($rose(resetn) |=> rangeCode === {pinCode(rangeSelectPinDriven[1],
      rangeSelectPinLevel[1]), pinCode(rangeSelectPinDriven[0], rangeSelectPinLevel[0])})
    else $error("range code not taken from pins");
  AST_FT_RESET:
    assert property ($rose(resetn) |-> fastTripSetting0 == 8'hBF && fastTripSetting1 == 8'hBF)
    else $error("fast-trip setting reset value wrong");
  AST_FT_SCALE0:
    assert property ($past(resetn) && $stable(rangeCode) && $stable(fastTripSetting0)
      |-> fastTripUv0 == ftUv(fastTripSetting0, rangeCode[1:0]))
    else $error("channel 0 fast-trip level off scale");
  AST_FT_SCALE1:
    assert property ($past(resetn) && $stable(rangeCode) && $stable(fastTripSetting1)
      |-> fastTripUv1 == ftUv(fastTripSetting1, rangeCode[3:2]))
    else $error("channel 1 fast-trip level off scale");
  AST_FT_WRITE:
    assert property ($changed(fastTripSetting0) || $changed(fastTripSetting1) |-> ##[0:1] sdaOe)
    else $error("fast-trip setting changed without a bus write");
  AST_RANGE_WRITE:
    assert property ($changed(rangeCode) && $past(resetn, 2) |-> ##[0:1] sdaOe)
    else $error("range code changed without a bus write");
  AST_ALERT_CAUSE:
    assert property ($rose(alertOut) |-> $past(sampleValid && powerGoodOut[sampleChannel], 2))
    else $error("alert rose without a powered sample");
  AST_PG_GATE:
    assert property ((powerGoodOut == 2'h0) [*2] |=> !alertOut)
    else $error("alert while no channel is power-good");
  AST_PROTECTION_MODE_PIN_IGNORED:
    assert property ($changed(protectionModePin) && !sampleValid && $stable(powerGoodOut)
      |-> ##2 $stable(alertOut))
    else $error("alert moved with protection mode");

  cover property ($rose(alertOut));
  cover property ($changed(rangeCode) && $past(resetn, 2));
  cover property ($changed(fastTripSetting0));
endmodule

bind cmpd_monitor cmpd_chk chk_u (.core_clk, .resetn, .sdaOe, .sampleValid, .sampleChannel,
  .powerGoodOut, .protectionModePin, .rangeSelectPinDriven, .rangeSelectPinLevel, .alertOut,
  .rangeCode, .fastTripSetting0, .fastTripSetting1, .fastTripUv0, .fastTripUv1);
`default_nettype wire

// *** testbench/cmpd_i2c_host.sv ***
// Two-wire host model: pointer write, one-byte write and read
`timescale 1ns/1ps
`default_nettype none
module cmpd_i2c_host (
  input wire logic core_clk,
  input wire logic sdaWire,
  output var logic scl,
  output var logic sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // Eight clocks a phase keeps SCL low well past the device's turnaround
  task automatic half();
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic start();
    sdaPull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaPull = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stop();
    sdaPull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaPull = 1'b0;
    half();
  endtask

  task automatic xbit(input logic b, output logic r);
    sdaPull = !b;
    half();
    scl = 1'b1;
    half();
    r = sdaWire;
    scl = 1'b0;
    half();
  endtask

  task automatic xbyte(input logic [7:0] o, output logic [7:0] i, output logic ackIn);
    logic r;
    for (int k = 7; k >= 0; k--) xbit(o[k], i[k]);
    xbit(1'b1, r);
    ackIn = !r;
  endtask

  // Read ends with a NACK, so its last acknowledge is not reported
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic rdOp,
                      inout logic [7:0] d, output logic ok);
    logic [7:0] junk;
    logic       k;
    start();
    xbyte({a, 1'b0}, junk, ok);
    xbyte(p, junk, k);
    ok &= k;
    if (rdOp) begin
      start();
      xbyte({a, 1'b1}, junk, k);
      ok &= k;
      xbyte(8'hFF, d, k);
    end else begin
      xbyte(d, junk, k);
      ok &= k;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// *** testbench/current_monitor_peak_detect_bench.sv ***
// Self-checking bench for the current monitor top
`timescale 1ns/1ps
`default_nettype none
module current_monitor_peak_detect_bench;
  localparam logic [6:0] ADDR = 7'h30;
  localparam logic [7:0] OFFS [15] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h10, 8'h22, 8'h23, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  localparam logic [7:0] RSTV [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'hBF, 8'hBF};
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sampleValid = 1'b0;
  logic        sampleChannel = 1'b0;
  logic [9:0]  sampleData = 10'h000;
  logic [1:0]  powerGoodOut = 2'h0;
  logic [1:0]  protectionModePin = 2'h0;
  logic [1:0]  channelStart = 2'h0;
  logic [1:0]  rangeSelectPinDriven = 2'h3;
  logic [1:0]  rangeSelectPinLevel = 2'h2;
  logic        scl;
  logic        hostPull;
  logic        sdaOe;
  logic        alertOut;
  logic [3:0]  rangeCode;
  logic [7:0]  fastTripSetting0;
  logic [7:0]  fastTripSetting1;
  logic [16:0] fastTripUv0;
  logic [16:0] fastTripUv1;
  logic [7:0]  d;
  logic        ok;
  wire logic   sdaIn;
  int          errors = 0;
  int          cmpCount = 0;

  // Open-drain wire with pull-up
  assign sdaIn = !(hostPull || sdaOe);
  always #2.5 core_clk = ~core_clk;

  cmpd_monitor dut_u (.core_clk, .resetn, .scl, .sdaIn, .sdaOut(), .sdaOe, .sampleValid,
    .sampleChannel, .sampleData, .powerGoodOut, .protectionModePin, .channelStart,
    .rangeSelectPinDriven, .rangeSelectPinLevel, .alertOut, .rangeCode, .fastTripSetting0,
    .fastTripSetting1, .fastTripUv0, .fastTripUv1);
  cmpd_i2c_host host_u (.core_clk, .sdaWire(sdaIn), .scl, .sdaPull(hostPull));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] t;
    logic       a;
    t = v;
    host_u.xfer(ADDR, p, 1'b0, t, a);
    chk("write ack", 16'h0001, {15'h0, a});
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] t;
    logic       a;
    host_u.xfer(ADDR, p, 1'b1, t, a);
    chk("read ack", 16'h0001, {15'h0, a});
    chk($sformatf("register %0h", p), {8'h00, exp}, {8'h00, t});
  endtask

  task automatic smp(input logic ch, input logic [9:0] v);
    @(posedge core_clk);
    #1;
    sampleValid = 1'b1;
    sampleChannel = ch;
    sampleData = v;
    @(posedge core_clk);
    #1;
    sampleValid = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  initial begin
    #500000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("range code", 16'h0006, {12'h0, rangeCode});
    foreach (OFFS[i]) rd(OFFS[i], RSTV[i]);
    rd(8'h33, 8'h06);
    wr(8'h33, 8'h05);
    chk("range code", 16'h0005, {12'h0, rangeCode});
    wr(8'h2E, 8'h55);
    chk("fast trip", 16'h0055, {8'h0, fastTripSetting0});
    rd(8'h2E, 8'h55);
    wr(8'h22, 8'h40);
    wr(8'h23, 8'hFC);
    rd(8'h23, 8'h00);
    smp(1'b0, 10'h2C5);
    chk("alert", 16'h0000, {15'h0, alertOut});
    rd(8'h00, 8'hB1);
    rd(8'h01, 8'h01);
    rd(8'h09, 8'h01);
    rd(8'h0A, 8'hB1);
    powerGoodOut = 2'h1;
    // Equal to the warning level must not alert
    smp(1'b0, 10'h100);
    chk("alert", 16'h0000, {15'h0, alertOut});
    protectionModePin = 2'h3;
    smp(1'b0, 10'h101);
    chk("alert", 16'h0001, {15'h0, alertOut});
    protectionModePin = 2'h0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("alert", 16'h0001, {15'h0, alertOut});
    powerGoodOut = 2'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("alert", 16'h0000, {15'h0, alertOut});
    rd(8'h08, 8'h40);
    rd(8'h09, 8'h00);
    wr(8'h0A, 8'h77);
    rd(8'h0A, 8'hB1);
    @(posedge core_clk);
    #1;
    channelStart = 2'h1;
    @(posedge core_clk);
    #1;
    channelStart = 2'h0;
    rd(8'h08, 8'hFF);
    rd(8'h0B, 8'h00);
    smp(1'b1, 10'h123);
    rd(8'h04, 8'h48);
    rd(8'h05, 8'h03);
    rd(8'h12, 8'h48);
    wr(8'h41, 8'h02);
    rd(8'h12, 8'h00);
    rd(8'h10, 8'hFF);
    d = 8'h11;
    host_u.xfer(7'h31, 8'h2F, 1'b0, d, ok);
    chk("foreign address ack", 16'h0000, {15'h0, ok});
    rd(8'h2F, 8'hBF);
    resetn = 1'b0;
    rangeSelectPinDriven = 2'h0;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("range code", 16'h0000, {12'h0, rangeCode});
    rd(8'h2E, 8'hBF);
    end_of_test();
  end
endmodule
`default_nettype wire
